// ### hw/bsc_pkg.sv
/*
  Constants shared by the boot serial command handler: command codes,
  ACK fields, sequence lengths and the fixed part of the product report.
  Assumes a byte-wide receiver and transmitter on the same clock.
*/
package bsc_pkg;

  // Operation command codes
  localparam logic [7:0] BSC_CMD_RAM_XFER = 8'h10;
  localparam logic [7:0] BSC_CMD_SUM = 8'h20;
  localparam logic [7:0] BSC_CMD_INFO = 8'h30;
  localparam logic [7:0] BSC_CMD_ERASE = 8'h40;
  localparam logic [7:0] BSC_CMD_PROTECT = 8'h60;
  localparam logic [7:0] BSC_ERASE_ENABLE = 8'h54;

  // ACK low nibbles and erase result codes
  localparam logic [3:0] BSC_ACK_RX_ERR = 4'h8;
  localparam logic [3:0] BSC_ACK_CMD_ERR = 4'h1;
  localparam logic [7:0] BSC_ERASE_END = 8'h4F;
  localparam logic [7:0] BSC_ERASE_FAIL = 8'h4C;
  localparam logic [7:0] BSC_ERASE_CONF_OK = 8'h5D;
  localparam logic [7:0] BSC_ERASE_CONF_ERR = 8'h60;

  // Reset values
  localparam logic [3:0] BSC_PREV_HI_RST = 4'h0;
  localparam logic [7:0] BSC_BYTE_RST = 8'h00;
  localparam logic [5:0] BSC_IDX_RST = 6'h00;

  // Last byte index of each sequence (index 0 is the ACK, or the result code in the erase result)
  localparam logic [5:0] BSC_LAST_ACK = 6'h00;
  localparam logic [5:0] BSC_LAST_SUM = 6'h03;
  localparam logic [5:0] BSC_LAST_INFO = 6'h3E;
  localparam logic [5:0] BSC_LAST_ERES = 6'h01;

  // Report field positions, counted from the first report byte
  localparam logic [5:0] BSC_R_SWVER_END = 6'h04;
  localparam logic [5:0] BSC_R_PART_BEG = 6'h04;
  localparam logic [5:0] BSC_R_PART_END = 6'h10;
  localparam logic [5:0] BSC_R_STAT_LO = 6'h28;
  localparam logic [5:0] BSC_R_STAT_HI = 6'h29;
  localparam int BSC_INFO_LEN = 61;

  // Fixed report bytes; zero entries 0 to 15, 40 and 41 are filled from live values
  localparam logic [7:0] BSC_INFO_ROM [BSC_INFO_LEN] = '{
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hF4, 8'hFE, 8'h02, 8'h00,
    8'h00, 8'h10, 8'h00, 8'h00,
    8'hFF, 8'h3D, 8'h00, 8'h00,
    8'hFF, 8'h3F, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00,
    8'hFF, 8'hFF, 8'h02, 8'h00,
    8'h20, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h08, 8'h00, 8'h00,
    8'h20
  };

  typedef enum logic [3:0] {
    BSC_S_CMD = 4'h1,
    BSC_S_EEN = 4'h2,
    BSC_S_SEND = 4'h4,
    BSC_S_ERUN = 4'h8
  } bsc_state_t;

  typedef enum logic [3:0] {
    BSC_Q_ACK = 4'h1,
    BSC_Q_SUM = 4'h2,
    BSC_Q_INFO = 4'h4,
    BSC_Q_ERES = 4'h8
  } bsc_seq_t;

endpackage : bsc_pkg

// ### hw/bsc_cmd_handler.sv
/*
  Boot serial command handler: takes operation command bytes from a
  receiver, answers ACKs, streams the flash SUM report, the product
  information report and the chip erase handshake.
  Assumes receiver, transmitter and flash controller share clk_in.
*/
// Contract
// - Receive error answers prev nibble with bit 3
// - SUM command echoed, then SUM report
// - Unknown command answers prev nibble with bit 0
// - SUM sent high byte then low byte
// - SUM checksum is negated byte sum
// - Info command echoed, then info report
// - Report starts with four version bytes ascending
// - Twelve byte space padded part string
// - Password start address bytes F4 FE 02 00
// - RAM start address bytes 00 10 00 00
// - RAM end addresses FF 3D, FF 3F
// - Bytes 32 to 39 are filler
// - Status word: active low protection, sector bits
// - Flash start and end address bytes
// - Sector count bytes 20 then 00
// - Sector layout: start, word size, count
// - Report ends with negated sum checksum
// - Erase command echoed, then await enable
// - Check enable: error, echo-and-erase, or reject
// - Erase result code then confirmation code
module bsc_cmd_handler #(
  parameter logic [95:0] PART_ID_P = 96'h5844_4556_3031_2020_2020_2020 // Arbitrary
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Receiver side
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_frame_err_in,
  input wire logic rx_parity_err_in,
  input wire logic rx_overrun_err_in,
  // Transmitter side
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  // Flash facts
  input wire logic [15:0] sum_value_in,
  input wire logic [31:0] sw_version_in,
  input wire logic read_prot_in,
  input wire logic write_prot_in,
  input wire logic sectored_in,
  // Chip erase engine
  output logic erase_start_out,
  input wire logic erase_done_in,
  input wire logic erase_ok_in
);
  import bsc_pkg::*;

  bsc_state_t st_ff;
  bsc_state_t ret_ff;
  bsc_seq_t seq_ff;
  logic [5:0] idx_ff;
  logic [7:0] ack_ff;
  logic [3:0] prev_hi_ff;
  logic [7:0] sum_ff;
  logic [15:0] sum_cap_ff;
  logic erase_ok_ff;
  logic tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic erase_start_ff;
  logic rx_err;
  logic rx_take;
  logic byte_done;
  logic [5:0] last_idx;
  logic last_byte;
  logic [7:0] nxt_tx_byte;
  logic [5:0] rom_idx;
  logic [31:0] ver_sh;
  logic [95:0] part_sh;
  logic [7:0] stat_lo;
  logic known_cmd;

  // Receive qualification
  assign rx_err = rx_frame_err_in | rx_parity_err_in | rx_overrun_err_in;
  assign rx_take = rx_valid_in & ((st_ff == BSC_S_CMD) | (st_ff == BSC_S_EEN));
  assign known_cmd = (rx_data_in == BSC_CMD_SUM) | (rx_data_in == BSC_CMD_INFO) |
                     (rx_data_in == BSC_CMD_ERASE) | (rx_data_in == BSC_CMD_RAM_XFER) |
                     (rx_data_in == BSC_CMD_PROTECT);

  // Transmit handshake and sequence end
  assign byte_done = tx_valid_ff & tx_ready_in;
  assign last_byte = (idx_ff == last_idx);

  // Length of the running sequence
  always_comb begin
    unique case (seq_ff)
      BSC_Q_ACK: last_idx = BSC_LAST_ACK;
      BSC_Q_SUM: last_idx = BSC_LAST_SUM;
      BSC_Q_INFO: last_idx = BSC_LAST_INFO;
      BSC_Q_ERES: last_idx = BSC_LAST_ERES;
      default: last_idx = BSC_LAST_ACK;
    endcase
  end

  // Byte to send at the current index
  always_comb begin
    rom_idx = idx_ff - 6'h01;
    ver_sh = sw_version_in >> {rom_idx[1:0], 3'b000};
    part_sh = PART_ID_P << {rom_idx - BSC_R_PART_BEG, 3'b000};
    stat_lo = {5'h00, ~sectored_in, ~write_prot_in, ~read_prot_in};
    nxt_tx_byte = ack_ff;
    if (seq_ff == BSC_Q_ERES) begin
      if (idx_ff == BSC_IDX_RST) begin
        nxt_tx_byte = erase_ok_ff ? BSC_ERASE_END : BSC_ERASE_FAIL;
      end else begin
        nxt_tx_byte = erase_ok_ff ? BSC_ERASE_CONF_OK : BSC_ERASE_CONF_ERR;
      end
    end else if (idx_ff != BSC_IDX_RST) begin
      if (last_byte && seq_ff != BSC_Q_ACK) begin
        nxt_tx_byte = 8'h00 - sum_ff;
      end else if (seq_ff == BSC_Q_SUM) begin
        nxt_tx_byte = (idx_ff == 6'h01) ? sum_cap_ff[15:8] : sum_cap_ff[7:0];
      end else if (rom_idx < BSC_R_SWVER_END) begin
        nxt_tx_byte = ver_sh[7:0];
      end else if (rom_idx < BSC_R_PART_END) begin
        nxt_tx_byte = part_sh[95:88];
      end else if (rom_idx == BSC_R_STAT_LO) begin
        nxt_tx_byte = stat_lo;
      end else if (rom_idx == BSC_R_STAT_HI) begin
        nxt_tx_byte = BSC_BYTE_RST;
      end else begin
        nxt_tx_byte = BSC_INFO_ROM[rom_idx];
      end
    end
  end

  // Main sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= BSC_S_CMD;
    end else begin
      unique case (st_ff)
        BSC_S_CMD, BSC_S_EEN: begin
          if (rx_take) begin
            st_ff <= BSC_S_SEND;
          end
        end
        BSC_S_SEND: begin
          if (byte_done && last_byte) begin
            st_ff <= ret_ff;
          end
        end
        BSC_S_ERUN: begin
          if (erase_done_in) begin
            st_ff <= BSC_S_SEND;
          end
        end
        default: st_ff <= BSC_S_CMD;
      endcase
    end
  end

  // Command decode: ACK value, sequence and follow-up state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= BSC_BYTE_RST;
      seq_ff <= BSC_Q_ACK;
      ret_ff <= BSC_S_CMD;
      sum_cap_ff <= 16'h0000;
    end else if (rx_take) begin
      seq_ff <= BSC_Q_ACK;
      ret_ff <= BSC_S_CMD;
      ack_ff <= rx_data_in;
      if (rx_err) begin
        ack_ff <= {prev_hi_ff, BSC_ACK_RX_ERR};
      end else if (st_ff == BSC_S_EEN) begin
        if (rx_data_in == BSC_ERASE_ENABLE) begin
          ret_ff <= BSC_S_ERUN;
        end else begin
          ack_ff <= {prev_hi_ff, BSC_ACK_CMD_ERR};
        end
      end else if (!known_cmd) begin
        ack_ff <= {prev_hi_ff, BSC_ACK_CMD_ERR};
      end else if (rx_data_in == BSC_CMD_SUM) begin
        seq_ff <= BSC_Q_SUM;
        sum_cap_ff <= sum_value_in;
      end else if (rx_data_in == BSC_CMD_INFO) begin
        seq_ff <= BSC_Q_INFO;
      end else if (rx_data_in == BSC_CMD_ERASE) begin
        ret_ff <= BSC_S_EEN;
      end
    end else if (st_ff == BSC_S_ERUN && erase_done_in) begin
      seq_ff <= BSC_Q_ERES;
      ret_ff <= BSC_S_CMD;
    end
  end

  // Upper nibble of the last clean command byte
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_hi_ff <= BSC_PREV_HI_RST;
    end else if (rx_take && !rx_err && st_ff == BSC_S_CMD) begin
      prev_hi_ff <= rx_data_in[7:4];
    end
  end

  // Byte index and running checksum
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_ff <= BSC_IDX_RST;
      sum_ff <= BSC_BYTE_RST;
    end else if (st_ff != BSC_S_SEND) begin
      idx_ff <= BSC_IDX_RST;
      sum_ff <= BSC_BYTE_RST;
    end else if (byte_done && !last_byte) begin
      idx_ff <= idx_ff + 6'h01;
      if (idx_ff != BSC_IDX_RST) begin
        sum_ff <= sum_ff + tx_data_ff;
      end
    end
  end

  // Transmit register: load when idle, drop after handshake
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= BSC_BYTE_RST;
    end else if (byte_done) begin
      tx_valid_ff <= 1'b0;
    end else if (st_ff == BSC_S_SEND && !tx_valid_ff) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= nxt_tx_byte;
    end
  end

  // Erase start pulse after the enable echo, and result capture
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      erase_start_ff <= 1'b0;
      erase_ok_ff <= 1'b0;
    end else begin
      erase_start_ff <= (st_ff == BSC_S_SEND) && byte_done && last_byte &&
                        (ret_ff == BSC_S_ERUN);
      if (st_ff == BSC_S_ERUN && erase_done_in) begin
        erase_ok_ff <= erase_ok_in;
      end
    end
  end

  assign tx_valid_out = tx_valid_ff;
  assign tx_data_out = tx_data_ff;
  assign erase_start_out = erase_start_ff;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_rxerr_ack: assert property (
    (rx_take && rx_err) |=> ack_ff == {$past(prev_hi_ff), BSC_ACK_RX_ERR})
    else $error("receive error ACK wrong");
  a_err_flag_src: assert property (
    (rx_take && rx_overrun_err_in && st_ff == BSC_S_CMD) |=> ack_ff[3])
    else $error("overrun not flagged");
  a_sum_echo: assert property (
    (rx_take && !rx_err && st_ff == BSC_S_CMD && rx_data_in == BSC_CMD_SUM)
    |=> ack_ff == BSC_CMD_SUM && seq_ff == BSC_Q_SUM ##1 tx_data_out == BSC_CMD_SUM)
    else $error("SUM echo wrong");
  a_bad_cmd_ack: assert property (
    (rx_take && !rx_err && st_ff == BSC_S_CMD && !known_cmd)
    |=> ack_ff == {$past(prev_hi_ff), BSC_ACK_CMD_ERR} && ret_ff == BSC_S_CMD)
    else $error("unknown command ACK wrong");
  a_sum_hi_first: assert property (
    (tx_valid_out && seq_ff == BSC_Q_SUM && idx_ff == 6'h01)
    |-> tx_data_out == sum_cap_ff[15:8])
    else $error("SUM high byte wrong");
  a_cks_zero: assert property (
    (byte_done && last_byte && seq_ff != BSC_Q_ACK && seq_ff != BSC_Q_ERES)
    |-> 8'(sum_ff + tx_data_out) == 8'h00)
    else $error("checksum does not cancel");
  a_info_pwaddr: assert property (
    (tx_valid_out && seq_ff == BSC_Q_INFO && idx_ff == 6'h11) |-> tx_data_out == 8'hF4)
    else $error("password address byte wrong");
  a_status_bits: assert property (
    (tx_valid_out && seq_ff == BSC_Q_INFO && idx_ff == 6'h29)
    |-> tx_data_out[7:3] == 5'h00 && tx_data_out[0] == ~$past(read_prot_in))
    else $error("status word wrong");
  a_erase_pulse: assert property (
    erase_start_out |-> st_ff == BSC_S_ERUN && $past(ack_ff) == BSC_ERASE_ENABLE)
    else $error("erase started without enable echo");
  a_erase_result: assert property (
    (tx_valid_out && seq_ff == BSC_Q_ERES && idx_ff == 6'h01)
    |-> tx_data_out == (erase_ok_ff ? BSC_ERASE_CONF_OK : BSC_ERASE_CONF_ERR))
    else $error("erase confirmation wrong");

  // Echo, answer timing and handshake checks
  a_answer_delay: assert property (
    rx_take |=> !tx_valid_out ##1 tx_valid_out && tx_data_out == $past(ack_ff))
    else $error("ACK not offered two edges after take");
  a_info_echo: assert property (
    (rx_take && !rx_err && st_ff == BSC_S_CMD && rx_data_in == BSC_CMD_INFO)
    |=> ack_ff == BSC_CMD_INFO && seq_ff == BSC_Q_INFO ##1 tx_data_out == BSC_CMD_INFO)
    else $error("info echo wrong");
  a_erase_echo: assert property (
    (rx_take && !rx_err && st_ff == BSC_S_CMD && rx_data_in == BSC_CMD_ERASE)
    |=> ack_ff == BSC_CMD_ERASE && ret_ff == BSC_S_EEN ##1 tx_data_out == BSC_CMD_ERASE)
    else $error("erase echo wrong");
  a_enable_reject: assert property (
    (rx_take && st_ff == BSC_S_EEN && (rx_err || rx_data_in != BSC_ERASE_ENABLE))
    |=> ret_ff == BSC_S_CMD && (ack_ff[3] || ack_ff[0]))
    else $error("bad enable byte accepted");
  a_erase_once: assert property (
    erase_start_out |=> !erase_start_out)
    else $error("erase start longer than one cycle");
  a_tx_hold: assert property (
    (tx_valid_out && !tx_ready_in) |=> tx_valid_out && $stable(tx_data_out))
    else $error("offered byte changed before taken");

  // Report field and erase result code checks
  a_sum_lo_second: assert property (
    (tx_valid_out && seq_ff == BSC_Q_SUM && idx_ff == 6'h02)
    |-> tx_data_out == sum_cap_ff[7:0])
    else $error("SUM low byte wrong");
  a_part_first: assert property (
    (tx_valid_out && seq_ff == BSC_Q_INFO && idx_ff == 6'h05)
    |-> tx_data_out == PART_ID_P[95:88])
    else $error("part string start wrong");
  a_sector_count: assert property (
    (tx_valid_out && seq_ff == BSC_Q_INFO && idx_ff == 6'h33)
    |-> tx_data_out == 8'h20)
    else $error("sector count wrong");
  a_erase_code: assert property (
    (tx_valid_out && seq_ff == BSC_Q_ERES && idx_ff == BSC_IDX_RST)
    |-> tx_data_out == (erase_ok_ff ? BSC_ERASE_END : BSC_ERASE_FAIL))
    else $error("erase result code wrong");

  c_sum_done: cover property (byte_done && last_byte && seq_ff == BSC_Q_SUM);
  c_info_done: cover property (byte_done && last_byte && seq_ff == BSC_Q_INFO);
  c_erase_ok: cover property (byte_done && last_byte && seq_ff == BSC_Q_ERES && erase_ok_ff);
  c_rx_error: cover property (rx_take && rx_err);
  c_enable_reject: cover property (rx_take && st_ff == BSC_S_EEN && !rx_err &&
                                   rx_data_in != BSC_ERASE_ENABLE);

endmodule // bsc_cmd_handler

// ### dv/bsc_ctrl_model.sv
/*
  Boot controller model: sends command bytes to the handler and collects
  the bytes that the handler offers, stalling ready at random when slow.
  Assumes the bench seeds $urandom and calls send from its main sequence.
*/
module bsc_ctrl_model (
  // Clock
  input wire logic clk_in,
  // Receiver side of the handler
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic [2:0] rx_err_out,
  // Transmitter side of the handler
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // Pacing
  input wire logic slow_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];

  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'hA5;
    rx_err_out = 3'h0;
    tx_ready_out = 1'b1;
  end

  // Ready pacing, prompt or random stalls
  always @(negedge clk_in) begin
    tx_ready_out <= slow_in ? 1'($urandom) : 1'b1;
  end

  // Collect every byte taken from the handler
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got_q.push_back(tx_data_in);
    end
  end

  // One byte per call; the line shows the inverse once released
  task automatic send(input logic [7:0] b, input logic [2:0] e);
    repeat (2) @(negedge clk_in);
    rx_valid_out = 1'b1;
    rx_data_out = b;
    rx_err_out = e;
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_data_out = ~b;
    rx_err_out = 3'h0;
  endtask
endmodule // bsc_ctrl_model

// ### dv/tb_top.sv
/*
  Bench for the boot serial command handler: a byte-level model predicts
  every answer byte and compares it with what the controller model takes.
  Assumes the handler and the controller model share clk_in.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bsc_pkg::*;
  localparam logic [95:0] PART_ID = 96'h4142_4344_3132_2020_2020_2020; // Arbitrary
  localparam logic [191:0] FIX_A = 192'hF4FE0200_00100000_FF3D0000_FF3F0000_00000000_00000000;
  localparam logic [151:0] FIX_B = 152'h00000100_FFFF0200_2000_0000010000080000_20;
  logic clk_in, rst_in, rx_valid, tx_valid, tx_ready, slow, erase_start, erase_done, erase_ok;
  logic rp, wp, sect;
  logic [7:0] rx_data, tx_data, cks, rnd;
  logic [2:0] rx_err;
  logic [15:0] sum_val;
  logic [31:0] sw_ver;
  logic [3:0] prev;
  logic [7:0] exp_q[$];
  int fails, tests_run, starts;

  bsc_cmd_handler #(.PART_ID_P(PART_ID)) u_bsc_cmd_handler (.clk_in(clk_in), .rst_in(rst_in),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_frame_err_in(rx_err[0]),
    .rx_parity_err_in(rx_err[1]), .rx_overrun_err_in(rx_err[2]), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_ready_in(tx_ready), .sum_value_in(sum_val),
    .sw_version_in(sw_ver), .read_prot_in(rp), .write_prot_in(wp), .sectored_in(sect),
    .erase_start_out(erase_start), .erase_done_in(erase_done), .erase_ok_in(erase_ok));
  bsc_ctrl_model u_bsc_ctrl_model (.clk_in(clk_in), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_err_out(rx_err), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_ready_out(tx_ready), .slow_in(slow));

  // Clock and erase start counter
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (erase_start === 1'b1) starts++;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Push one expected byte, keeping a running sum for checksums
  task automatic pb(input logic [7:0] b);
    exp_q.push_back(b);
    cks = cks + b;
  endtask

  // Compare every predicted byte with the bytes taken, bounded wait
  task automatic drain();
    int n;
    while (exp_q.size() > 0) begin
      n = 0;
      while (u_bsc_ctrl_model.got_q.size() == 0 && n < 400) begin
        @(negedge clk_in);
        n++;
      end
      if (n >= 400) begin
        fails++;
        summarize();
      end
      check("tx byte", u_bsc_ctrl_model.got_q.pop_front(), exp_q.pop_front());
    end
  endtask

  // One command byte and its whole predicted answer
  task automatic cmd(input logic [7:0] b, input logic [2:0] e);
    u_bsc_ctrl_model.send(b, e);
    if (e != 3'h0) pb({prev, BSC_ACK_RX_ERR});
    else if (b inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h60}) pb(b);
    else pb({prev, BSC_ACK_CMD_ERR});
    if (e == 3'h0) prev = b[7:4];
    cks = 8'h00;
    if (e == 3'h0 && b == 8'h20) begin
      pb(sum_val[15:8]);
      pb(sum_val[7:0]);
      pb(-cks);
    end
    if (e == 3'h0 && b == 8'h30) begin
      for (int i = 0; i < 4; i++) pb(sw_ver[8*i+:8]);
      for (int i = 11; i >= 0; i--) pb(PART_ID[8*i+:8]);
      for (int i = 23; i >= 0; i--) pb(FIX_A[8*i+:8]);
      pb({5'h00, ~sect, ~wp, ~rp});
      pb(8'h00);
      for (int i = 18; i >= 0; i--) pb(FIX_B[8*i+:8]);
      pb(-cks);
    end
    drain();
  endtask

  // Erase command, enable byte and, if accepted, the engine result
  task automatic erase(input logic [7:0] en, input logic [2:0] e, input logic ok);
    int s0;
    int n;
    cmd(8'h40, 3'h0);
    s0 = starts;
    u_bsc_ctrl_model.send(en, e);
    if (e != 3'h0) pb({prev, BSC_ACK_RX_ERR});
    else if (en == 8'h54) pb(en);
    else pb({prev, BSC_ACK_CMD_ERR});
    drain();
    n = 0;
    while (starts == s0 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    check("erase start", 8'(starts - s0), (e == 3'h0 && en == 8'h54) ? 8'h01 : 8'h00);
    if (e == 3'h0 && en == 8'h54) begin
      erase_ok = ok;
      erase_done = 1'b1;
      @(negedge clk_in);
      erase_done = 1'b0;
      erase_ok = ~ok;
      pb(ok ? 8'h4F : 8'h4C);
      pb(ok ? 8'h5D : 8'h60);
      drain();
    end
  endtask

  initial begin
    fails = 0;
    tests_run = 0;
    starts = 0;
    prev = 4'h0;
    slow = 1'b0;
    erase_done = 1'b0;
    erase_ok = 1'b0;
    rst_in = 1'b1;
    void'($urandom(16580));
    sum_val = 16'($urandom);
    sw_ver = $urandom;
    {rp, wp, sect} = 3'($urandom);
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    cmd(8'h55, 3'h0);
    foreach (FIX_A[i]) if (i < 3) cmd(8'h20, 3'h1 << i);
    cmd(8'h20, 3'h0);
    slow = 1'b1;
    cmd(8'h20, 3'h0);
    cmd(8'h30, 3'h0);
    {rp, wp, sect} = ~{rp, wp, sect};
    cmd(8'h30, 3'h0);
    cmd(8'h10, 3'h0);
    cmd(8'h60, 3'h0);
    // Random bytes kept off the defined codes so each one is rejected
    for (int k = 0; k < 6; k++) begin
      rnd = 8'($urandom);
      if (rnd inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h60}) rnd = rnd ^ 8'h01;
      cmd(rnd, 3'h0);
    end
    erase(8'h54, 3'h0, 1'b1);
    erase(8'h54, 3'h0, 1'b0);
    erase(8'h55, 3'h0, 1'b1);
    erase(8'h54, 3'h2, 1'b1);
    // Mid-run reset: the remembered nibble must start again from zero
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    prev = 4'h0;
    cmd(8'h30, 3'h4);
    summarize();
  end
endmodule // tb_top
